/* bench/slwc_chk.sv */
`timescale 1ns/1ps
module slwc_chk
  import slwc_pkg::*;
(
  // Watched ports
  input wire logic                      core_clk_i,
  input wire logic                      rst_i,
  input wire logic                      display_en_i,
  input wire logic [1:0]                load_i,
  input wire logic [31:0]               pin_en_lo_i,
  input wire logic [31:0]               pin_en_hi_i,
  input wire logic                      fd_ie_i,
  input wire logic                      fd_clr_i,
  input wire logic [slwc_pkg::PINS-1:0] pin_o,
  input wire logic [1:0]                load_o,
  input wire logic                      active_o,
  input wire logic                      fd_done_o,
  input wire logic                      irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_reset_clears: assert property (disable iff (1'b0) rst_i |=>
    pin_o == '0 && !fd_done_o && !irq_o && !active_o)
    else $error("outputs not cleared by reset");
  a_stop_low:
    assert property (!display_en_i |=> pin_o == '0)
    else $error("stopped display drives a pin");
  a_stop_idle:
    assert property (!display_en_i |=> !active_o)
    else $error("stopped display still active");
  a_pin_mask:
    assert property (1'b1 |=>
      (pin_o & ~$past({pin_en_hi_i, pin_en_lo_i})) == '0)
    else $error("disabled pin driven");
  a_done_sticky:
    assert property (fd_done_o && !fd_clr_i |=> fd_done_o)
    else $error("done flag dropped without clear");
  a_irq_cause:
    assert property (irq_o |-> fd_done_o || $past(fd_done_o))
    else $error("irq without done flag");
  a_irq_masked:
    assert property (!fd_ie_i |=> !irq_o)
    else $error("irq while disabled");
  a_load_follow:
    assert property (1'b1 |=> load_o == $past(load_i))
    else $error("load setting not applied");
  c_done: cover property (fd_done_o);
  c_irq: cover property (irq_o);
  c_active: cover property (active_o);
endmodule : slwc_chk

bind slwc_top slwc_chk slwc_chk_inst (.*);

/* bench/slwc_glass.sv */
`timescale 1ns/1ps
// Passive glass: reports how many electrodes are pulled high
module slwc_glass
  import slwc_pkg::*;
(
  input  wire logic [slwc_pkg::PINS-1:0] pin_i,
  output logic      [6:0]                hi_count_o
);
  assign hi_count_o = 7'($countones(pin_i));
endmodule : slwc_glass

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import slwc_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ref_edge_i, alt_edge_i, src_alt_i, display_en_i, blink_en_i;
  logic blink_alt_i, wait_i, stop_i, pump_en_i, fd_start_i, fd_ie_i;
  logic fd_clr_i, pump_fast_o, active_o, fd_done_o, irq_o, exp_run;
  logic exp_bp, exp_fp;
  logic [1:0] alt_div_i, mode_i, lowpower_i, load_i, load_o;
  logic [2:0] duty_i, blink_rate_i, fd_psc_i, fd_win_i, phase_o;
  logic [31:0] pin_en_lo_i, pin_en_hi_i;
  logic [PINS*4-1:0] bp_phase_i;
  logic [PINS*8-1:0] seg_i, alt_seg_i;
  logic [PINS-1:0] fd_pin_i, pin_o;
  logic [FD_CNT_W-1:0] fd_count_o;
  logic [6:0] hi_count;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  slwc_top slwc_top_inst (.*);
  slwc_glass slwc_glass_inst (.pin_i(pin_o), .hi_count_o(hi_count));

  always #50 core_clk_i = ~core_clk_i;

  // Source edges and run-time ceiling
  always @(posedge core_clk_i) begin
    #1;
    cycles++;
    ref_edge_i = (cycles % 4) == 0;
    alt_edge_i = (cycles % 3) == 0;
    if (cycles == 10000) begin
      errors++;
      final_report();
    end
  end

  task automatic final_report;
    if (errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick

  task automatic check(input string nm, input logic [63:0] e,
                       input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : check

  task automatic fd_run(input logic [2:0] psc, input logic [2:0] win);
    int n;
    int lo;
    int step;
    step = 1 << psc;
    lo = (4 << win) * step;
    fd_psc_i = psc;
    fd_win_i = win;
    fd_ie_i = psc[0] ^ win[0];
    fd_start_i = 1'b1;
    tick(1);
    fd_start_i = 1'b0;
    n = 1;
    while (fd_done_o !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    check("fd_len", 1, n >= lo - step && n <= lo + 2 * step + 4);
    if (lo == 4) check("fd_walk", 5, n);
    check("fd_count", 0, fd_count_o);
    check("fd_irq", fd_ie_i, irq_o);
    tick(3);
    check("fd_sticky", 1, fd_done_o);
    fd_clr_i = 1'b1;
    tick(1);
    fd_clr_i = 1'b0;
    tick(1);
    check("fd_clr", 0, fd_done_o);
    check("irq_clr", 0, irq_o);
  endtask : fd_run

  initial begin
    {src_alt_i, display_en_i, blink_en_i, blink_alt_i, wait_i} = '0;
    {stop_i, pump_en_i, fd_start_i, fd_ie_i, fd_clr_i} = '0;
    {ref_edge_i, alt_edge_i, alt_div_i, mode_i, lowpower_i, load_i} = '0;
    {duty_i, blink_rate_i, fd_psc_i, fd_win_i} = '0;
    pin_en_lo_i = '1;
    pin_en_hi_i = '0;
    bp_phase_i = {PINS{4'h1}};
    seg_i = '1;
    alt_seg_i = '1;
    fd_pin_i = '1;
    tick(16);
    rst_i = 1'b0;
    tick(4);
    check("pin_stop", 0, pin_o);
    check("glass_hi", 0, hi_count);
    display_en_i = 1'b1;
    duty_i = 3'h3;
    for (int lp = 0; lp < 4; lp++) begin
      for (int ws = 0; ws < 3; ws++) begin
        lowpower_i = lp[1:0];
        {stop_i, wait_i} = ws[1:0];
        mode_i = ws[1:0];
        src_alt_i = lp[0];
        alt_div_i = lp[1:0];
        blink_en_i = lp[1];
        blink_alt_i = lp[0];
        blink_rate_i = 3'(ws + lp);
        load_i = lp[1:0];
        pump_en_i = ws[0];
        tick(3);
        exp_run = !((stop_i && lp[0]) || (wait_i && lp[1]));
        check("active", exp_run, active_o);
        check("pin_hi_off", 0, pin_o[63:32]);
        check("load", lp, load_o);
        check("pump", ws[0] && lp == 0, pump_fast_o);
      end
    end
    // One backplane on phase B and one frontplane, all three modes
    {lowpower_i, wait_i, stop_i, blink_en_i, src_alt_i} = '0;
    pin_en_lo_i = '0;
    pin_en_hi_i = 32'h0000_0003;
    bp_phase_i[32*4 +: 8] = 8'h02;
    seg_i[33*8 +: 8] = 8'h05;
    alt_seg_i[33*8 +: 8] = 8'h20;
    for (int m = 0; m < 3; m++) begin
      mode_i = m[1:0];
      tick(2);
      for (int c = 0; c < 20; c++) begin
        exp_bp = (phase_o == 3'h1);
        if (m == 0) exp_fp = (phase_o == 3'h0) || (phase_o == 3'h2);
        else if (m == 1) exp_fp = (phase_o == 3'h1);
        else exp_fp = 1'b0;
        check("bp_pin", exp_bp, pin_o[32]);
        check("fp_pin", exp_fp, pin_o[33]);
        check("glass", 7'(exp_bp) + 7'(exp_fp), hi_count);
        tick(1);
      end
    end
    display_en_i = 1'b0;
    for (int k = 0; k < 8; k++) fd_run(k[2:0], 3'h0);
    for (int k = 1; k < 8; k++) fd_run(3'h0, k[2:0]);
    final_report();
  end
endmodule : tb_top

/* hw/slwc_clk_if.sv */
`timescale 1ns/1ps
// Ticks from the clock prescaler to the waveform logic (lcd_tick) and the fault-detect logic (fd_tick)
interface slwc_clk_if;
  logic lcd_tick;
  logic fd_tick;
  modport src (output lcd_tick, output fd_tick);
  modport dst (input lcd_tick, input fd_tick);
endinterface : slwc_clk_if

/* hw/slwc_clkgen.sv */
`timescale 1ns/1ps
module slwc_clkgen
  import slwc_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Sources, as one-cycle edges
  input  wire logic       ref_edge_i,
  input  wire logic       alt_edge_i,
  input  wire logic       src_alt_i,
  input  wire logic [1:0] alt_div_i,
  input  wire logic [2:0] fd_psc_i,
  // Ticks
  slwc_clk_if.src         ck
);
  logic [9:0] adiv_reg;
  logic [6:0] fdiv_reg;
  logic [9:0] amask;
  logic       alt_tick;

  always_comb begin
    case (alt_div_i)
      ADIV64:  amask = DIV64_M;
      ADIV256: amask = DIV256_M;
      ADIV512: amask = DIV512_M;
      default: amask = '0;
    endcase
  end
  assign alt_tick = alt_edge_i && ((adiv_reg & amask) == amask);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      adiv_reg <= '0;
    end else if (alt_edge_i) begin
      adiv_reg <= adiv_reg + 10'h001;
    end
  end

  assign ck.lcd_tick = src_alt_i ? alt_tick : ref_edge_i;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      fdiv_reg <= '0;
    end else begin
      fdiv_reg <= fdiv_reg + 7'h01;
    end
  end

  assign ck.fd_tick = (fd_psc_i == 3'h0) ? 1'b1 :
    ((fdiv_reg & ((7'h01 << fd_psc_i) - 7'h01)) == '0);
endmodule : slwc_clkgen

/* hw/slwc_pkg.sv */
// Behaviour
// - Software picks LCD clock: default low-frequency reference or alternate internal reference.
// - Alternate clock is divided by 1, 64, 256 or 512 first.
// - Duty 1/1 to 1/8, one backplane per duty step.
// - Each backplane pin takes one phase A to H, or none.
// - Frontplane pin holds eight phase bits; segment on in each set phase.
// - Display modes normal, alternate and blank.
// - Blank blink blanks during blink period, normal otherwise.
// - Alternate blink shows alternate data in blink period, duty below five only.
// - Blink rate is LCD clock over two to the 12 through 19.
// - Fault sample clock is bus clock over 1 to 128.
// - Fault window lasts 4 to 512 sample clocks.
// - Fault measurement end raises complete event, interrupt when enabled.
// - Two-bit low-power setting picks running in wait and stop.
// - Four-level load setting picks charge-pump clock or glass load.
// - Fault counter readable, samples counted in last window.
// - Stopped display: generator idle, enabled pins drive low.
// - Segment byte bit 7 is phase H, bit 0 phase A.
// - Sixty-four pin enables, low word pins 0-31, high word 32-63.
package slwc_pkg;
  localparam int PINS      = 64;
  localparam int PHASES    = 8;
  localparam int PH_W      = 4;
  localparam int ALT_MAX_BP = 4;
  localparam int BLINK_BASE = 12;
  localparam int WIN_BASE   = 2;
  localparam int FD_CNT_W   = 10;
  localparam logic [3:0] PH_NONE = 4'h0;
  localparam logic [1:0] ADIV1 = 2'h0;
  localparam logic [1:0] ADIV64 = 2'h1;
  localparam logic [1:0] ADIV256 = 2'h2;
  localparam logic [1:0] ADIV512 = 2'h3;
  localparam logic [9:0] DIV64_M = 10'h03f;
  localparam logic [9:0] DIV256_M = 10'h0ff;
  localparam logic [9:0] DIV512_M = 10'h1ff;
  localparam logic [1:0] LP_WAIT_STOP = 2'h0;
  localparam logic [1:0] LP_WAIT_ONLY = 2'h1;
  localparam logic [1:0] LP_STOP_ONLY = 2'h2;
  localparam logic [1:0] LP_NONE      = 2'h3;
  typedef enum logic [1:0] {
    SLWC_NORMAL = 2'b00,
    SLWC_ALT    = 2'b01,
    SLWC_BLANK  = 2'b10
  } slwc_mode_e;
  typedef enum logic [1:0] {
    SLWC_FD_IDLE = 2'b00,
    SLWC_FD_RUN  = 2'b01
  } slwc_fd_e;
endpackage : slwc_pkg

/* hw/slwc_top.sv */
`timescale 1ns/1ps
module slwc_top
  import slwc_pkg::*;
(
  // Clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_i,
  // Clock sources, one-cycle edges in core_clk
  input  wire logic                   ref_edge_i,
  input  wire logic                   alt_edge_i,
  input  wire logic                   src_alt_i,
  input  wire logic [1:0]             alt_div_i,
  // Display control
  input  wire logic                   display_en_i,
  input  wire logic [2:0]             duty_i,
  input  wire logic [1:0]             mode_i,
  input  wire logic                   blink_en_i,
  input  wire logic                   blink_alt_i,
  input  wire logic [2:0]             blink_rate_i,
  input  wire logic [1:0]             lowpower_i,
  input  wire logic                   wait_i,
  input  wire logic                   stop_i,
  input  wire logic [1:0]             load_i,
  input  wire logic                   pump_en_i,
  // Pins
  input  wire logic [31:0]            pin_en_lo_i,
  input  wire logic [31:0]            pin_en_hi_i,
  input  wire logic [slwc_pkg::PINS*4-1:0] bp_phase_i,
  input  wire logic [slwc_pkg::PINS*8-1:0] seg_i,
  input  wire logic [slwc_pkg::PINS*8-1:0] alt_seg_i,
  // Fault detect
  input  wire logic                   fd_start_i,
  input  wire logic [slwc_pkg::PINS-1:0] fd_pin_i,
  input  wire logic [2:0]             fd_psc_i,
  input  wire logic [2:0]             fd_win_i,
  input  wire logic                   fd_ie_i,
  input  wire logic                   fd_clr_i,
  // Outputs
  output logic [slwc_pkg::PINS-1:0]   pin_o,
  output logic [2:0]                  phase_o,
  output logic                        pump_fast_o,
  output logic [1:0]                  load_o,
  output logic                        active_o,
  output logic [slwc_pkg::FD_CNT_W-1:0] fd_count_o,
  output logic                        fd_done_o,
  output logic                        irq_o
);
  import slwc_pkg::*;

  slwc_clk_if ck ();
  slwc_clkgen u_clkgen (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ref_edge_i (ref_edge_i),
    .alt_edge_i (alt_edge_i),
    .src_alt_i  (src_alt_i),
    .alt_div_i  (alt_div_i),
    .fd_psc_i   (fd_psc_i),
    .ck         (ck.src)
  );

  logic [2:0]  phase_reg;
  logic [18:0] blink_cnt_reg;
  logic        blink_on;
  logic        run;
  logic        alt_ok;
  logic [PINS-1:0] pin_en;
  logic [PINS-1:0] pin_next;
  slwc_fd_e    fd_state_reg;
  logic [9:0]  fd_win_cnt_reg;
  logic [9:0]  fd_samp_reg;
  logic [9:0]  fd_win_len;
  logic        fd_set;

  assign pin_en = {pin_en_hi_i, pin_en_lo_i};
  // alternate only up to four backplanes
  assign alt_ok = (duty_i < 3'(ALT_MAX_BP));

  always_comb begin
    case (lowpower_i)
      LP_WAIT_STOP: run = display_en_i;
      LP_WAIT_ONLY: run = display_en_i && !stop_i;
      LP_STOP_ONLY: run = display_en_i && !wait_i;
      LP_NONE:      run = display_en_i && !wait_i && !stop_i;
      default:      run = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !run) begin
      phase_reg <= '0;
    end else if (ck.lcd_tick) begin
      phase_reg <= (phase_reg >= duty_i) ? 3'h0 : phase_reg + 3'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !run) begin
      blink_cnt_reg <= '0;
    end else if (ck.lcd_tick) begin
      blink_cnt_reg <= blink_cnt_reg + 19'h00001;
    end
  end
  assign blink_on = blink_en_i &&
    blink_cnt_reg[5'(BLINK_BASE) - 5'd1 + 5'(blink_rate_i)];

  generate
    for (genvar p = 0; p < PINS; p++) begin : g_pin
      logic [3:0] bp;
      logic [7:0] prim;
      logic [7:0] alt;
      logic       seg_on;
      logic       altv;
      assign bp   = bp_phase_i[p*4 +: 4];
      // bit 7 phase H, bit 0 phase A
      assign prim = seg_i[p*8 +: 8];
      assign alt  = alt_seg_i[p*8 +: 8];
      assign altv = alt_ok && ((mode_i == SLWC_ALT) ||
                    (blink_on && blink_alt_i));
      always_comb begin
        if (mode_i == SLWC_BLANK || (blink_on && !blink_alt_i)) begin
          seg_on = 1'b0;
        end else if (altv) begin
          seg_on = alt[3'(phase_reg + 3'h4)];
        end else begin
          seg_on = prim[phase_reg];
        end
        if (bp != PH_NONE) begin
          pin_next[p] = (bp - 4'h1 == {1'b0, phase_reg});
        end else begin
          pin_next[p] = seg_on;
        end
        if (!run || !pin_en[p]) begin
          pin_next[p] = 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pin_o    <= '0;
      phase_o  <= '0;
      active_o <= 1'b0;
    end else begin
      pin_o    <= pin_next;
      phase_o  <= phase_reg;
      active_o <= run;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      load_o      <= '0;
      pump_fast_o <= 1'b0;
    end else begin
      load_o      <= load_i;
      pump_fast_o <= pump_en_i && (load_i == 2'h0);
    end
  end

  // window length
  // Four bits so that the largest window does not wrap the shift amount
  assign fd_win_len = 10'h001 << (4'(WIN_BASE) + {1'b0, fd_win_i});
  assign fd_set = (fd_state_reg == SLWC_FD_RUN) && ck.fd_tick &&
                  (fd_win_cnt_reg == fd_win_len - 10'h001);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      fd_state_reg   <= SLWC_FD_IDLE;
      fd_win_cnt_reg <= '0;
      fd_samp_reg    <= '0;
      fd_count_o     <= '0;
    end else begin
      case (fd_state_reg)
        SLWC_FD_IDLE: begin
          if (fd_start_i) begin
            fd_state_reg   <= SLWC_FD_RUN;
            fd_win_cnt_reg <= '0;
            fd_samp_reg    <= '0;
          end
        end
        SLWC_FD_RUN: begin
          if (ck.fd_tick) begin
            fd_samp_reg    <= fd_samp_reg +
                              10'(|(pin_o & fd_pin_i));
            fd_win_cnt_reg <= fd_win_cnt_reg + 10'h001;
            if (fd_win_cnt_reg == fd_win_len - 10'h001) begin
              fd_count_o   <= fd_samp_reg +
                              10'(|(pin_o & fd_pin_i));
              fd_state_reg <= SLWC_FD_IDLE;
            end
          end
        end
        default: fd_state_reg <= SLWC_FD_IDLE;
      endcase
    end
  end

  // completion event, sticky flag, set wins
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      fd_done_o <= 1'b0;
      irq_o     <= 1'b0;
    end else begin
      fd_done_o <= fd_set || (fd_done_o && !fd_clr_i);
      irq_o     <= fd_ie_i && (fd_set || (fd_done_o && !fd_clr_i));
    end
  end
endmodule : slwc_top
